// File: ceu_pkg.sv
/*
 * Constants, types and functional notes of the instruction exception unit.
 * Assumes a core pipeline that presents decoded instructions one per strobe.
 */
package ceu_pkg;
    localparam int unsigned ADDR_W          = 32;
    localparam logic [31:0] STACK_STEP      = 32'h0000_0004;
    localparam logic [1:0]  ALIGN_MASK      = 2'h3;
    localparam logic [7:0]  VEC_ILLEGAL     = 8'h04;
    localparam logic [7:0]  VEC_SLOT        = 8'h06;
    localparam logic [7:0]  VEC_ADDR_ERR    = 8'h09;
    localparam logic [7:0]  VEC_NMI         = 8'h0B;
    localparam logic [3:0]  NMI_MASK_LEVEL  = 4'hF;
    localparam int unsigned MASK_LSB        = 4;

    typedef enum logic [2:0] {
        CEU_CAUSE_NONE,
        CEU_CAUSE_TRAP,
        CEU_CAUSE_SLOT,
        CEU_CAUSE_ILLEGAL,
        CEU_CAUSE_ADDR,
        CEU_CAUSE_IRQ
    } ceu_cause_t;
endpackage

// File: ceu_align_chk.sv
/*
 * Word alignment checker.
 * Assumes a byte address; flags any address not on a four-byte boundary.
 */
module ceu_align_chk #(
    parameter int unsigned W = 32
) (
    input  wire logic [W-1:0] addr,
    input  wire logic         check,
    output logic              misaligned
);
    assign misaligned = check && ((addr[1:0] & ceu_pkg::ALIGN_MASK) != 2'h0);
endmodule

// File: ceu_accept.sv
/*
 * Acceptance gate for pending address errors and interrupts.
 * Assumes decode-stage qualifiers are valid while a decode strobe is high.
 */
module ceu_accept (
    input  wire logic       in_slot,
    input  wire logic       after_sysreg,
    input  wire logic       addr_err_pend,
    input  wire logic       irq_pend,
    input  wire logic       irq_is_nmi,
    input  wire logic [3:0] irq_level,
    input  wire logic [3:0] mask_field,
    output logic            take_addr_err,
    output logic            take_irq
);
    logic level_ok;
    // Level must exceed the mask field unless nonmaskable.
    assign level_ok = irq_is_nmi || (irq_level > mask_field);
    // Slot decode blocks both; register transfer shadow blocks only interrupts.
    assign take_addr_err = addr_err_pend && !in_slot;
    assign take_irq      = irq_pend && level_ok && !in_slot && !after_sysreg && !take_addr_err;
endmodule

// File: ceu_top.sv
/*
 * Instruction exception sequencer: raises trap, illegal and slot exceptions,
 * gates interrupts and address errors at decode, and runs the two-word stack
 * push and vector fetch over a simple memory bus.
 * Assumes the memory bus answers each request with MEM_ACK, one at a time.
 */
module ceu_top #(
    parameter int unsigned AW = 32
) (
    input  wire logic          CLK,
    input  wire logic          RESET_N,
    input  wire logic          CE,
    input  wire logic          DEC_VALID,
    input  wire logic          DEC_UNDEFINED,
    input  wire logic          DEC_TRAP_CALL,
    input  wire logic [7:0]    DEC_TRAP_VECTOR,
    input  wire logic          DEC_DELAYED_BRANCH,
    input  wire logic          DEC_PC_REWRITE,
    input  wire logic          DEC_SYSREG_XFER,
    input  wire logic [AW-1:0] DEC_PC,
    input  wire logic [AW-1:0] DEC_NEXT_PC,
    input  wire logic [AW-1:0] BRANCH_TARGET,
    input  wire logic          INSN_DONE,
    input  wire logic          ADDR_ERR_IN,
    input  wire logic          IRQ_REQ,
    input  wire logic          IRQ_NMI,
    input  wire logic [3:0]    IRQ_LEVEL,
    input  wire logic [7:0]    IRQ_VECTOR,
    input  wire logic [31:0]   STATUS_WORD,
    input  wire logic [AW-1:0] STACK_PTR,
    input  wire logic [AW-1:0] VECTOR_TABLE_BASE,
    output logic               MEM_REQ,
    output logic               MEM_WE,
    output logic [AW-1:0]      MEM_ADDR,
    output logic [31:0]        MEM_WDATA,
    input  wire logic [31:0]   MEM_RDATA,
    input  wire logic          MEM_ACK,
    output logic               EXC_BUSY,
    output logic               EXC_STALL,
    output logic               JUMP_VALID,
    output logic [AW-1:0]      JUMP_ADDR,
    output logic [AW-1:0]      SP_OUT,
    output logic               SP_WRITE,
    output logic               MASK_WRITE,
    output logic [3:0]         MASK_VALUE,
    output logic               ADDR_ERR_TAKEN,
    output logic               IRQ_TAKEN
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef enum logic [2:0] {
        S_IDLE, S_WAIT_DONE, S_PUSH_SR, S_PUSH_PC, S_VEC_READ, S_JUMP
    } ceu_state_t;

    ceu_state_t           st_q, st_d;
    ceu_pkg::ceu_cause_t  cause_q, cause_d;
    logic [AW-1:0]        ret_q, ret_d;
    logic [AW-1:0]        sp_q, sp_d;
    logic [7:0]           vec_q, vec_d;
    logic [31:0]          sr_q, sr_d;
    logic [3:0]           lvl_q, lvl_d;
    logic                 slot_q, slot_d;
    logic                 sysreg_q, sysreg_d;
    logic [AW-1:0]        tgt_q, tgt_d;
    logic                 ae_pend_q, ae_pend_d;
    logic                 stk_ae_q, stk_ae_d;
    logic                 jmp_q, jmp_d;
    logic [AW-1:0]        jaddr_q, jaddr_d;
    logic                 ae_taken_q, ae_taken_d;
    logic                 irq_taken_q, irq_taken_d;
    logic                 req_q, req_d;
    logic                 nmi_q, nmi_d;

    logic                 sp_mis, vbr_mis;
    logic                 take_ae, take_irq;
    logic [AW-1:0]        sp_dec, vec_addr;

    ceu_align_chk #(.W(AW)) u_sp_chk (
        .addr       (sp_q),
        .check      (1'b1),
        .misaligned (sp_mis)
    );

    ceu_align_chk #(.W(AW)) u_vbr_chk (
        .addr       (VECTOR_TABLE_BASE),
        .check      (1'b1),
        .misaligned (vbr_mis)
    );

    ceu_accept u_accept (
        .in_slot       (slot_q),
        .after_sysreg  (sysreg_q),
        .addr_err_pend (ae_pend_q),
        .irq_pend      (IRQ_REQ),
        .irq_is_nmi    (IRQ_NMI),
        .irq_level     (IRQ_LEVEL),
        .mask_field    (STATUS_WORD[ceu_pkg::MASK_LSB +: 4]),
        .take_addr_err (take_ae),
        .take_irq      (take_irq)
    );

    localparam logic [AW-1:0] STACK_STEP_W = AW'(ceu_pkg::STACK_STEP);

    assign sp_dec   = sp_q - STACK_STEP_W;
    // Vector address is base plus four times the vector number.
    assign vec_addr = VECTOR_TABLE_BASE + {{(AW-10){1'b0}}, vec_q, 2'b00};

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always_comb begin
        st_d        = st_q;
        cause_d     = cause_q;
        ret_d       = ret_q;
        sp_d        = sp_q;
        vec_d       = vec_q;
        sr_d        = sr_q;
        lvl_d       = lvl_q;
        slot_d      = slot_q;
        sysreg_d    = sysreg_q;
        tgt_d       = tgt_q;
        ae_pend_d   = ae_pend_q;
        stk_ae_d    = stk_ae_q;
        jmp_d       = 1'b0;
        jaddr_d     = jaddr_q;
        ae_taken_d  = 1'b0;
        irq_taken_d = 1'b0;
        req_d       = req_q;
        nmi_d       = nmi_q;
        unique case (st_q)
            S_IDLE: begin
                if (DEC_VALID) begin
                    slot_d   = DEC_DELAYED_BRANCH;
                    sysreg_d = DEC_SYSREG_XFER;
                    if (DEC_DELAYED_BRANCH) begin
                        tgt_d = BRANCH_TARGET;
                    end
                    if (slot_q && (DEC_UNDEFINED || DEC_PC_REWRITE || DEC_TRAP_CALL
                                   || DEC_DELAYED_BRANCH)) begin
                        // Slot fault at decode, return to branch target.
                        cause_d = ceu_pkg::CEU_CAUSE_SLOT;
                        ret_d   = tgt_q;
                        vec_d   = ceu_pkg::VEC_SLOT;
                        st_d    = S_PUSH_SR;
                    end else if (take_ae) begin
                        // Wait for the faulting instruction to finish.
                        cause_d    = ceu_pkg::CEU_CAUSE_ADDR;
                        vec_d      = ceu_pkg::VEC_ADDR_ERR;
                        ae_pend_d  = 1'b0;
                        ae_taken_d = 1'b1;
                        st_d       = S_WAIT_DONE;
                    end else if (take_irq) begin
                        cause_d     = ceu_pkg::CEU_CAUSE_IRQ;
                        vec_d       = IRQ_VECTOR;
                        ret_d       = DEC_PC;
                        lvl_d       = IRQ_NMI ? ceu_pkg::NMI_MASK_LEVEL : IRQ_LEVEL;
                        nmi_d       = IRQ_NMI;
                        irq_taken_d = 1'b1;
                        st_d        = S_PUSH_SR;
                    end else if (DEC_UNDEFINED) begin
                        // Own start address is returned to.
                        cause_d = ceu_pkg::CEU_CAUSE_ILLEGAL;
                        ret_d   = DEC_PC;
                        vec_d   = ceu_pkg::VEC_ILLEGAL;
                        st_d    = S_PUSH_SR;
                    end else if (DEC_TRAP_CALL) begin
                        // Vector from the instruction, return past it.
                        cause_d = ceu_pkg::CEU_CAUSE_TRAP;
                        ret_d   = DEC_NEXT_PC;
                        vec_d   = DEC_TRAP_VECTOR;
                        st_d    = S_PUSH_SR;
                    end
                    if (st_d != S_IDLE) begin
                        sp_d   = STACK_PTR;
                        sr_d   = STATUS_WORD;
                        slot_d = 1'b0;
                    end
                end
            end
            S_WAIT_DONE: begin
                if (INSN_DONE) begin
                    ret_d = DEC_NEXT_PC;
                    st_d  = S_PUSH_SR;
                end
            end
            S_PUSH_SR: begin
                req_d = 1'b1;
                if (req_q && MEM_ACK) begin
                    req_d = 1'b0;
                    sp_d  = sp_dec;
                    st_d  = S_PUSH_PC;
                end
            end
            S_PUSH_PC: begin
                req_d = 1'b1;
                if (req_q && MEM_ACK) begin
                    req_d = 1'b0;
                    sp_d  = sp_dec;
                    st_d  = S_VEC_READ;
                end
            end
            S_VEC_READ: begin
                req_d = 1'b1;
                if (req_q && MEM_ACK) begin
                    req_d   = 1'b0;
                    jaddr_d = MEM_RDATA[AW-1:0];
                    st_d    = S_JUMP;
                end
            end
            S_JUMP: begin
                // Handler jump is issued at once unless a stacking fault is pending, no slot follows.
                jmp_d = 1'b1;
                st_d  = S_IDLE;
                if (stk_ae_q) begin
                    // Stacking fault: push an address error frame below the first, returning to the fetched handler, error input held off.
                    stk_ae_d   = 1'b0;
                    cause_d    = ceu_pkg::CEU_CAUSE_ADDR;
                    vec_d      = ceu_pkg::VEC_ADDR_ERR;
                    ret_d      = jaddr_q;
                    ae_taken_d = 1'b1;
                    jmp_d      = 1'b0;
                    sr_d       = STATUS_WORD;
                    sp_d       = sp_q;
                    st_d       = S_PUSH_SR;
                end
            end
            default: st_d = S_IDLE;
        endcase
        // Errors raised while they cannot be taken are kept, except while a stacking fault is
        // pending. A new error beats a same-cycle acceptance so that it is never lost.
        if (ADDR_ERR_IN && !stk_ae_q) begin
            ae_pend_d = 1'b1;
        end
        // Misaligned pointer or base marks a stacking-time address error, except while stacking an address error.
        if ((st_q == S_PUSH_SR && sp_mis) || (st_q == S_VEC_READ && vbr_mis)) begin
            if (cause_q != ceu_pkg::CEU_CAUSE_ADDR || !ae_taken_q) begin
                stk_ae_d = (cause_q != ceu_pkg::CEU_CAUSE_ADDR);
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_q        <= S_IDLE;
            cause_q     <= ceu_pkg::CEU_CAUSE_NONE;
            ret_q       <= '0;
            sp_q        <= '0;
            vec_q       <= 8'h00;
            sr_q        <= 32'h0000_0000;
            lvl_q       <= 4'h0;
            slot_q      <= 1'b0;
            sysreg_q    <= 1'b0;
            tgt_q       <= '0;
            ae_pend_q   <= 1'b0;
            stk_ae_q    <= 1'b0;
            jmp_q       <= 1'b0;
            jaddr_q     <= '0;
            ae_taken_q  <= 1'b0;
            irq_taken_q <= 1'b0;
            req_q       <= 1'b0;
            nmi_q       <= 1'b0;
        end else if (CE) begin
            st_q        <= st_d;
            cause_q     <= cause_d;
            ret_q       <= ret_d;
            sp_q        <= sp_d;
            vec_q       <= vec_d;
            sr_q        <= sr_d;
            lvl_q       <= lvl_d;
            slot_q      <= slot_d;
            sysreg_q    <= sysreg_d;
            tgt_q       <= tgt_d;
            ae_pend_q   <= ae_pend_d;
            stk_ae_q    <= stk_ae_d;
            jmp_q       <= jmp_d;
            jaddr_q     <= jaddr_d;
            ae_taken_q  <= ae_taken_d;
            irq_taken_q <= irq_taken_d;
            req_q       <= req_d;
            nmi_q       <= nmi_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Each push writes one word below the current pointer, so the status word
    // lands above the return address; a misaligned pointer is still driven.
    assign MEM_REQ        = req_q;
    assign MEM_WE         = (st_q == S_PUSH_SR) || (st_q == S_PUSH_PC);
    assign MEM_ADDR       = (st_q == S_VEC_READ) ? vec_addr : sp_dec;
    assign MEM_WDATA      = (st_q == S_PUSH_SR) ? sr_q : 32'(ret_q);
    assign EXC_BUSY       = (st_q != S_IDLE);
    assign EXC_STALL      = (st_q != S_IDLE) || jmp_q;
    assign JUMP_VALID     = jmp_q;
    assign JUMP_ADDR      = jaddr_q;
    assign SP_OUT         = sp_q;
    assign SP_WRITE       = jmp_q;
    assign MASK_WRITE     = jmp_q && (cause_q == ceu_pkg::CEU_CAUSE_IRQ);
    assign MASK_VALUE     = lvl_q;
    assign ADDR_ERR_TAKEN = ae_taken_q;
    assign IRQ_TAKEN      = irq_taken_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_frame_order;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && st_q == S_PUSH_SR && MEM_ACK && req_q) |=> (st_q == S_PUSH_PC);
    endproperty
    a_frame_order: assert property (p_frame_order) else $error("status word not followed by return");

    property p_step;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && req_q && MEM_ACK && MEM_WE) |=> (sp_q == $past(sp_q) - STACK_STEP_W);
    endproperty
    a_step: assert property (p_step) else $error("stack pointer not stepped by four");

    property p_slot_block;
        @(posedge CLK) disable iff (!RESET_N)
        slot_q |-> !take_ae && !take_irq;
    endproperty
    a_slot_block: assert property (p_slot_block) else $error("exception taken in delay slot");

    property p_sysreg_block;
        @(posedge CLK) disable iff (!RESET_N)
        sysreg_q |-> !take_irq;
    endproperty
    a_sysreg_block: assert property (p_sysreg_block) else $error("interrupt after register transfer");

    property p_mask;
        @(posedge CLK) disable iff (!RESET_N)
        (take_irq && !IRQ_NMI) |-> (IRQ_LEVEL > STATUS_WORD[ceu_pkg::MASK_LSB +: 4]);
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt below mask accepted");

    property p_vec_addr;
        @(posedge CLK) disable iff (!RESET_N)
        (st_q == S_VEC_READ) |-> (MEM_ADDR == VECTOR_TABLE_BASE + AW'({vec_q, 2'b00}));
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");

    property p_jump_once;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && JUMP_VALID) |=> (CE -> !JUMP_VALID);
    endproperty
    a_jump_once: assert property (p_jump_once) else $error("handler jump repeated");

    property p_slot_ret;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && st_q == S_IDLE && DEC_VALID && slot_q && DEC_UNDEFINED) |=>
            (cause_q == ceu_pkg::CEU_CAUSE_SLOT && ret_q == $past(tgt_q));
    endproperty
    a_slot_ret: assert property (p_slot_ret) else $error("slot return address wrong");
endmodule

// File: ceu_mem_model.sv
/*
 * Memory bus partner holding the stack and the vector table.
 * Assumes each request is held until MEM_ACK; the bench sets the latency.
 */
module ceu_mem_model (
    input  wire logic        clk,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic [2:0]  lat,
    output logic             ack,
    output logic [31:0]      rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0]  cnt;
    logic [31:0] wr_addr[$];
    logic [31:0] wr_data[$];
    logic [31:0] rd_addr[$];
    initial begin
        ack   = 1'b0;
        cnt   = 3'h0;
        rdata = 32'h0000_0000;
    end
    // **********************************************************************
    // Bus answer
    // **********************************************************************
    // Read data flips every cycle outside a read acknowledge, so a late sample
    // shows up as a wrong handler instead of a lucky match.
    always @(posedge clk) begin
        ack   <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack) begin
            if (cnt >= lat) begin
                ack <= 1'b1;
                cnt <= 3'h0;
                if (we) begin
                    wr_addr.push_back(addr);
                    wr_data.push_back(wdata);
                end else begin
                    rd_addr.push_back(addr);
                    rdata <= 32'h5A00_0000 ^ addr;
                end
            end else begin
                cnt <= cnt + 3'h1;
            end
        end
    end
endmodule

// File: testbench.sv
/*
 * Self-checking bench of the instruction exception unit.
 * Assumes ceu_pkg, ceu_top and ceu_mem_model are compiled before it.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0]  K_UND = 5'h10, K_TRP = 5'h08, K_DBR = 5'h04;
    localparam logic [4:0]  K_PCR = 5'h02, K_SYS = 5'h01, K_NOP = 5'h00;
    localparam logic [31:0] SP0 = 32'h1000_0100, SR0 = 32'h0000_0030, VB0 = 32'h0800_0000;
    logic        CLK, RESET_N, DEC_VALID, DEC_UNDEFINED, DEC_TRAP_CALL, DEC_DELAYED_BRANCH;
    logic        DEC_PC_REWRITE, DEC_SYSREG_XFER, INSN_DONE, ADDR_ERR_IN, IRQ_REQ, IRQ_NMI;
    logic        MEM_REQ, MEM_WE, MEM_ACK, EXC_BUSY, EXC_STALL, JUMP_VALID, SP_WRITE;
    logic        MASK_WRITE, ADDR_ERR_TAKEN, IRQ_TAKEN, seen_ae, seen_irq, CE;
    logic [7:0]  DEC_TRAP_VECTOR, IRQ_VECTOR;
    logic [3:0]  IRQ_LEVEL, MASK_VALUE, mv, flg;
    logic [2:0]  lat;
    logic [31:0] DEC_PC, DEC_NEXT_PC, BRANCH_TARGET, STATUS_WORD, STACK_PTR, VECTOR_TABLE_BASE;
    logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, JUMP_ADDR, SP_OUT, ja, spo;
    int          mismatches, checked, cycles;

    ceu_top #(.AW(32)) u_ceu_top (.CLK, .RESET_N, .CE, .DEC_VALID, .DEC_UNDEFINED,
        .DEC_TRAP_CALL, .DEC_TRAP_VECTOR, .DEC_DELAYED_BRANCH, .DEC_PC_REWRITE,
        .DEC_SYSREG_XFER, .DEC_PC, .DEC_NEXT_PC, .BRANCH_TARGET, .INSN_DONE, .ADDR_ERR_IN,
        .IRQ_REQ, .IRQ_NMI, .IRQ_LEVEL, .IRQ_VECTOR, .STATUS_WORD, .STACK_PTR,
        .VECTOR_TABLE_BASE, .MEM_REQ, .MEM_WE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA, .MEM_ACK,
        .EXC_BUSY, .EXC_STALL, .JUMP_VALID, .JUMP_ADDR, .SP_OUT, .SP_WRITE, .MASK_WRITE,
        .MASK_VALUE, .ADDR_ERR_TAKEN, .IRQ_TAKEN);
    ceu_mem_model u_ceu_mem_model (.clk(CLK), .req(MEM_REQ), .we(MEM_WE), .addr(MEM_ADDR),
        .wdata(MEM_WDATA), .lat, .ack(MEM_ACK), .rdata(MEM_RDATA));

    initial begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    always @(negedge CLK) begin
        if (ADDR_ERR_TAKEN === 1'b1) seen_ae = 1'b1;
        if (IRQ_TAKEN === 1'b1) seen_irq = 1'b1;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // **********************************************************************
    // Shared tasks
    // **********************************************************************
    task automatic give_verdict();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic dec(input logic [4:0] cls, input logic [31:0] pc);
        @(posedge CLK);
        DEC_VALID <= 1'b1;
        {DEC_UNDEFINED, DEC_TRAP_CALL, DEC_DELAYED_BRANCH, DEC_PC_REWRITE, DEC_SYSREG_XFER} <= cls;
        DEC_PC <= pc;
        DEC_NEXT_PC <= pc + 32'h0000_0002;
        BRANCH_TARGET <= pc + 32'h0000_0100;
    endtask
    task automatic idle();
        @(posedge CLK);
        DEC_VALID <= 1'b0;
        {DEC_UNDEFINED, DEC_TRAP_CALL, DEC_DELAYED_BRANCH, DEC_PC_REWRITE, DEC_SYSREG_XFER} <= K_NOP;
    endtask
    task automatic clr();
        repeat (4) @(posedge CLK);
        u_ceu_mem_model.wr_addr.delete();
        u_ceu_mem_model.wr_data.delete();
        u_ceu_mem_model.rd_addr.delete();
        seen_ae = 1'b0;
        seen_irq = 1'b0;
    endtask
    task automatic wait_jump();
        int n;
        n = 0;
        ja = 32'h0000_0000;
        while (n < 200) begin
            @(negedge CLK);
            n++;
            if (JUMP_VALID === 1'b1) begin
                ja = JUMP_ADDR;
                spo = SP_OUT;
                mv = MASK_VALUE;
                flg = {EXC_BUSY, EXC_STALL, SP_WRITE, MASK_WRITE};
                n = 1000;
            end
        end
        chk(n, 1000);
        @(posedge CLK);
    endtask
    task automatic frame(input logic [31:0] ret, input logic [7:0] vec);
        chk(u_ceu_mem_model.wr_addr[0], SP0 - 32'h0000_0004);
        chk(u_ceu_mem_model.wr_data[0], SR0);
        chk(u_ceu_mem_model.wr_addr[1], SP0 - 32'h0000_0008);
        chk(u_ceu_mem_model.wr_data[1], ret);
        chk(u_ceu_mem_model.rd_addr[0], VB0 + {22'h0, vec, 2'h0});
        chk(ja, 32'h5A00_0000 ^ (VB0 + {22'h0, vec, 2'h0}));
        chk(spo, SP0 - 32'h0000_0008);
        chk(flg, 4'h6);
    endtask

    // **********************************************************************
    // Scenarios
    // **********************************************************************
    task automatic t_trap();
        for (int i = 0; i < 2; i++) begin
            clr();
            lat <= 3'(i * 3);
            dec(K_TRP, 32'h0000_2000);
            idle();
            if (i == 1) begin
                CE <= 1'b0;
                repeat (3) @(posedge CLK);
                chk({EXC_BUSY, MEM_REQ}, 32'h0000_0002);
                CE <= 1'b1;
            end
            wait_jump();
            frame(32'h0000_2002, 8'h21);
        end
    endtask
    task automatic t_slot();
        logic [4:0] kinds[4] = '{K_UND, K_PCR, K_TRP, K_DBR};
        for (int i = 0; i < 4; i++) begin
            clr();
            dec(K_DBR, 32'h0000_2100);
            dec(kinds[i], 32'h0000_2102);
            idle();
            wait_jump();
            frame(32'h0000_2200, ceu_pkg::VEC_SLOT);
        end
        clr();
        dec(K_UND, 32'h0000_2300);
        idle();
        wait_jump();
        frame(32'h0000_2300, ceu_pkg::VEC_ILLEGAL);
    endtask
    task automatic t_irq_hold();
        for (int i = 0; i < 2; i++) begin
            clr();
            dec(K_NOP, 32'h0000_2400);
            dec(i == 0 ? K_SYS : K_DBR, 32'h0000_2402);
            dec(K_NOP, 32'h0000_2404);
            IRQ_REQ <= 1'b1;
            idle();
            repeat (3) @(negedge CLK);
            chk(seen_irq, 1'b0);
            dec(K_NOP, 32'h0000_2406);
            idle();
            wait_jump();
            IRQ_REQ <= 1'b0;
            chk(seen_irq, 1'b1);
            chk(mv, 4'h5);
            chk(flg, 4'h7);
            chk(u_ceu_mem_model.rd_addr[0], VB0 + 32'h0000_0100);
        end
    endtask
    task automatic t_mask();
        clr();
        IRQ_LEVEL <= 4'h3;
        dec(K_NOP, 32'h0000_2500);
        IRQ_REQ <= 1'b1;
        idle();
        repeat (3) @(negedge CLK);
        chk(seen_irq, 1'b0);
        dec(K_NOP, 32'h0000_2502);
        IRQ_NMI <= 1'b1;
        idle();
        wait_jump();
        IRQ_REQ <= 1'b0;
        IRQ_NMI <= 1'b0;
        IRQ_LEVEL <= 4'h5;
        chk(mv, 4'hF);
        chk(flg, 4'h7);
    endtask
    task automatic t_addr_err();
        clr();
        dec(K_DBR, 32'h0000_2600);
        ADDR_ERR_IN <= 1'b1;
        idle();
        ADDR_ERR_IN <= 1'b0;
        dec(K_NOP, 32'h0000_2602);
        idle();
        repeat (3) @(negedge CLK);
        chk(seen_ae, 1'b0);
        dec(K_NOP, 32'h0000_2604);
        idle();
        INSN_DONE <= 1'b1;
        @(posedge CLK);
        INSN_DONE <= 1'b0;
        wait_jump();
        chk(seen_ae, 1'b1);
        chk(u_ceu_mem_model.wr_data[0], SR0);
        chk(u_ceu_mem_model.wr_data[1], 32'h0000_2606);
        chk(flg, 4'h6);
        chk(u_ceu_mem_model.rd_addr[0], VB0 + 32'h0000_0024);
    endtask
    task automatic t_fault(input logic [31:0] sp, input logic [31:0] vb);
        clr();
        STACK_PTR <= sp;
        VECTOR_TABLE_BASE <= vb;
        dec(K_TRP, 32'h0000_2700);
        idle();
        wait_jump();
        chk(seen_ae, 1'b1);
        chk(u_ceu_mem_model.wr_addr[0], sp - 32'h0000_0004);
        chk(u_ceu_mem_model.wr_addr[1], sp - 32'h0000_0008);
        chk(u_ceu_mem_model.rd_addr[$], vb + 32'h0000_0024);
        chk(flg, 4'h6);
        STACK_PTR <= SP0;
        VECTOR_TABLE_BASE <= VB0;
    endtask

    initial begin
        {RESET_N, DEC_VALID, INSN_DONE, ADDR_ERR_IN, IRQ_REQ, IRQ_NMI} = 6'h00;
        {DEC_UNDEFINED, DEC_TRAP_CALL, DEC_DELAYED_BRANCH, DEC_PC_REWRITE, DEC_SYSREG_XFER} = K_NOP;
        {DEC_PC, DEC_NEXT_PC, BRANCH_TARGET} = '0;
        DEC_TRAP_VECTOR = 8'h21;
        IRQ_VECTOR = 8'h40;
        IRQ_LEVEL = 4'h5;
        STATUS_WORD = SR0;
        STACK_PTR = SP0;
        VECTOR_TABLE_BASE = VB0;
        lat = 3'h1;
        CE = 1'b1;
        {mismatches, checked, cycles} = '0;
        // Reset is applied only here, before any bus access can be open.
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        t_trap();
        t_slot();
        t_irq_hold();
        t_mask();
        t_addr_err();
        t_fault(SP0 + 32'h0000_0002, VB0);
        t_fault(SP0, VB0 + 32'h0000_0002);
        give_verdict();
    end
endmodule
